// File: fsoc_bcm.sv
/* Body controller model: select pin driver and pulled-up shared fault line. Assumes one clock. */
`timescale 1ns/1ps
`default_nettype none
module fsoc_bcm (
	input wire logic clk_sys_i,
	input wire logic sel_req_i,
	input wire logic other_pull_i,
	input wire logic oe_n_i,
	output logic failsafe_select_pin_o = 1'b1,
	output logic fault_line_o
);
	always @(posedge clk_sys_i) failsafe_select_pin_o <= sel_req_i;
	// Unknown enable counts as released: the pull-up wins
	assign fault_line_o = (oe_n_i !== 1'b0) && !other_pull_i;
endmodule
`default_nettype wire

// File: fsoc_cfg.svh
/*
 Constants for the fail-safe output control block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef FSOC_CFG_SVH
`define FSOC_CFG_SVH

`define FSOC_NCH 12
`define FSOC_HIGH_PAT_RST 12'hfff
`define FSOC_LOW_PAT_RST 12'h000
`define FSOC_POLICY_RST 1'b1
`define FSOC_CH_NONE 12'h000
`define FSOC_SYNC_W 3
`define FSOC_SYNC_RST 3'h7

`endif

// File: fsoc_ctrl.sv
/*
 Fail-safe output control: mode entry, pattern selection from the select pin,
 fault line drive and sense, and the fault reaction on the channel outputs.
 Assumes the diagnostic circuits deliver per-channel fault levels on the
 system clock, and that the non-volatile store is written by a one-cycle
 program strobe from the host side.
*/
`timescale 1ns/1ps
`default_nettype none

`include "fsoc_cfg.svh"

module fsoc_ctrl
	import fsoc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Supervision
	input wire logic watchdog_en_i,
	input wire logic host_comm_lost_i,
	// Body controller pins
	input wire logic failsafe_select_pin_i,
	input wire logic fault_line_i,
	output logic fault_line_o,
	output logic fault_line_oe_o,
	// Non-volatile programming
	input wire logic nv_prog_i,
	input wire fsoc_ch_t nv_high_pattern_i,
	input wire fsoc_ch_t nv_low_pattern_i,
	input wire logic nv_policy_i,
	// Normal-mode enables from the host register
	input wire fsoc_ch_t host_enable_i,
	// Diagnostics
	input wire fsoc_ch_t channel_fault_i,
	// Status and drive
	output fsoc_mode_t mode_o,
	output fsoc_ch_t channel_enable_bits_o,
	output fsoc_ch_t output_on_o,
	output logic all_off_on_fault_policy_o
);

	fsoc_mode_t mode_q;
	fsoc_ch_t select_high_enable_pattern_q;
	fsoc_ch_t select_low_enable_pattern_q;
	logic all_off_on_fault_policy_q;
	logic [`FSOC_SYNC_W-1:0] sel_sync_q;
	logic [`FSOC_SYNC_W-1:0] flt_sync_q;
	logic sel_q;
	logic flt_low_q;
	fsoc_ch_t channel_enable_bits_q;
	fsoc_ch_t output_on_q;
	logic pull_low_q;
	fsoc_ch_t output_on_d;

	// Fail-safe is left only by reset; host return is out of scope here
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			mode_q <= FSOC_NORMAL;
		end else if (ce_i) begin
			if (watchdog_en_i && host_comm_lost_i) begin
				mode_q <= FSOC_FAILSAFE;
			end
		end
	end

	// Reset values stand in for the factory-burnt store contents
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			select_high_enable_pattern_q <= `FSOC_HIGH_PAT_RST;
			select_low_enable_pattern_q <= `FSOC_LOW_PAT_RST;
			all_off_on_fault_policy_q <= `FSOC_POLICY_RST;
		end else if (ce_i && nv_prog_i) begin
			select_high_enable_pattern_q <= nv_high_pattern_i;
			select_low_enable_pattern_q <= nv_low_pattern_i;
			all_off_on_fault_policy_q <= nv_policy_i;
		end
	end

	// Pin synchronisers: first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sel_sync_q <= `FSOC_SYNC_RST;
			flt_sync_q <= `FSOC_SYNC_RST;
			sel_q <= 1'b1;
			flt_low_q <= 1'b0;
		end else if (ce_i) begin
			sel_sync_q <= {sel_sync_q[1:0], failsafe_select_pin_i};
			flt_sync_q <= {flt_sync_q[1:0], fault_line_i};
			if (sel_sync_q[1] == sel_sync_q[2]) begin
				sel_q <= sel_sync_q[2];
			end
			if (flt_sync_q[1] == flt_sync_q[2]) begin
				flt_low_q <= ~flt_sync_q[2];
			end
		end
	end

	// Channel enable bits follow the selected pattern in fail-safe mode
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			channel_enable_bits_q <= `FSOC_CH_NONE;
		end else if (ce_i) begin
			if (mode_q == FSOC_FAILSAFE) begin
				if (sel_q) begin
					channel_enable_bits_q <= select_high_enable_pattern_q;
				end else begin
					channel_enable_bits_q <= select_low_enable_pattern_q;
				end
			end else begin
				channel_enable_bits_q <= host_enable_i;
			end
		end
	end

	// Failed channels are always off; retry is implicit, a cleared fault re-enables
	always_comb begin
		output_on_d = channel_enable_bits_q & ~channel_fault_i;
		if (mode_q == FSOC_FAILSAFE && flt_low_q && all_off_on_fault_policy_q) begin
			output_on_d = `FSOC_CH_NONE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			output_on_q <= `FSOC_CH_NONE;
			pull_low_q <= 1'b0;
		end else if (ce_i) begin
			output_on_q <= output_on_d;
			pull_low_q <= |channel_fault_i;
		end
	end

	// Open drain: output data always low, enable low means driving
	assign fault_line_o = 1'b0;
	assign fault_line_oe_o = ~pull_low_q;
	assign mode_o = mode_q;
	assign channel_enable_bits_o = channel_enable_bits_q;
	assign output_on_o = output_on_q;
	assign all_off_on_fault_policy_o = all_off_on_fault_policy_q;

endmodule

`default_nettype wire

// File: fsoc_ctrl_checker.sv
/* Port assertions for fsoc_ctrl. Assumes ce_i held high. */
`timescale 1ns/1ps
`default_nettype none
module fsoc_chk
	import fsoc_pkg::*;
(
	input wire logic clk_sys_i, srst_i, watchdog_en_i, host_comm_lost_i, fault_line_i,
	input wire logic fault_line_o, fault_line_oe_o, nv_prog_i, nv_policy_i,
	input wire fsoc_ch_t channel_fault_i, output_on_o,
	input wire fsoc_mode_t mode_o,
	input wire logic all_off_on_fault_policy_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence line_low_s;
		(mode_o == FSOC_FAILSAFE && all_off_on_fault_policy_o && !fault_line_i) [*5];
	endsequence
	chk_mode_entry: assert property (watchdog_en_i && host_comm_lost_i |=>
		mode_o == FSOC_FAILSAFE) else $error("no entry");
	chk_pull_fault: assert property (|channel_fault_i |=> !fault_line_oe_o)
		else $error("no pull");
	chk_pull_release: assert property (channel_fault_i == '0 |=> fault_line_oe_o)
		else $error("no release");
	chk_drain_low: assert property (fault_line_o == 1'b0) else $error("drain");
	chk_failed_off: assert property (|channel_fault_i |=>
		(output_on_o & $past(channel_fault_i)) == '0) else $error("failed on");
	chk_policy_store: assert property (nv_prog_i |=>
		all_off_on_fault_policy_o == $past(nv_policy_i)) else $error("store");
	chk_policy_keep: assert property (!nv_prog_i |=>
		$stable(all_off_on_fault_policy_o)) else $error("keep");
	chk_all_off: assert property (line_low_s |=> output_on_o == '0)
		else $error("not all off");
endmodule
bind fsoc_ctrl fsoc_chk chk_u (.*);
`default_nettype wire

// File: fsoc_pkg.sv
/*
 Types for the fail-safe output control block.
 Assumes fsoc_cfg.svh is on the include path.
*/
`include "fsoc_cfg.svh"

package fsoc_pkg;
	typedef logic [`FSOC_NCH-1:0] fsoc_ch_t;
	typedef enum logic [0:0] {
		FSOC_NORMAL = 1'b0,
		FSOC_FAILSAFE = 1'b1
	} fsoc_mode_t;
endpackage

// File: test_failsafe_output_control.sv
/* Self-checking bench for fsoc_ctrl. Assumes fsoc_bcm and the checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module test_failsafe_output_control;
	import fsoc_pkg::*;
	logic clk_sys_i = 0, srst_i = 1, wd = 0, sel = 1, oth = 0, prog = 0, pol = 1;
	logic line, oe_n, pin, ap;
	fsoc_ch_t hi = '1, lo = '0, flt = '0, en, on, mh = '1, ml = '0;
	fsoc_mode_t md;
	int n_fail = 0, cmp_count = 0, mp = 1;
	always #10 clk_sys_i = ~clk_sys_i;
	fsoc_ctrl dut_u (.clk_sys_i, .srst_i, .ce_i(1'b1), .watchdog_en_i(wd), .host_comm_lost_i(wd),
		.failsafe_select_pin_i(pin), .fault_line_i(line), .fault_line_o(), .fault_line_oe_o(oe_n),
		.nv_prog_i(prog), .nv_high_pattern_i(hi), .nv_low_pattern_i(lo), .nv_policy_i(pol),
		.host_enable_i(hi), .channel_fault_i(flt), .mode_o(md), .channel_enable_bits_o(en),
		.output_on_o(on), .all_off_on_fault_policy_o(ap));
	fsoc_bcm bcm_u (.clk_sys_i, .sel_req_i(sel), .other_pull_i(oth), .oe_n_i(oe_n),
		.failsafe_select_pin_o(pin), .fault_line_o(line));
	task chk(input logic [11:0] s, input logic [11:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task nv(input fsoc_ch_t h, input fsoc_ch_t l, input logic p);
		@(posedge clk_sys_i);
		{hi, lo, pol, prog} <= {h, l, p, 1'b1};
		@(posedge clk_sys_i) prog <= 0;
		{mh, ml, mp} = {h, l, 32'(p)};
		#1 chk(ap, p);
	endtask
	// Eight cycles cover pin flop, three-stage filter and two output stages
	task step(input logic s, input fsoc_ch_t f, input logic o);
		fsoc_ch_t e;
		@(posedge clk_sys_i);
		{sel, flt, oth} <= {s, f, o};
		repeat (8) @(posedge clk_sys_i);
		e = (s ? mh : ml) & ~f;
		if (mp == 1 && (f != '0 || o)) e = '0;
		#1 chk(on, e);
		chk(en, s ? mh : ml);
		chk(oe_n, f == '0);
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		n_fail++;
		close_out;
	end
	initial begin
		void'($urandom(39042));
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 0;
		#1 chk(md, FSOC_NORMAL);
		chk(ap, 1'b1);
		@(posedge clk_sys_i) wd <= 1;
		repeat (2) @(posedge clk_sys_i);
		#1 chk(md, FSOC_FAILSAFE);
		for (int i = 0; i < 5; i++) begin
			if (i > 0) nv(12'($urandom), 12'($urandom), i[0]);
			step(1, '0, 0);
			step(0, '0, 0);
			step(1, fsoc_ch_t'(1) << ($urandom % 12), 0);
			step(1, '0, 1);
			step(1, '0, 0);
		end
		close_out;
	end
endmodule
`default_nettype wire
